// ===== include/rswc_pkg.sv
/*
 * Shared constants for the reset, sleep and wake controller: bus map,
 * field positions, reset values, timing counts, cause codes and states.
 * Assumes a 20 MHz core clock and a 32-bit AHB-Lite register bus.
 */
package rswc_pkg;
	// register byte addresses, one aligned word each
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_INTC    = 8'h04;
	localparam logic [7:0] ADDR_STAT    = 8'h08;
	localparam logic [7:0] ADDR_KEEP    = 8'h0C;
	localparam logic [7:0] ADDR_SCRATCH = 8'h10;
	localparam logic [7:0] ADDR_PORT    = 8'h14;
	// control register fields
	localparam int CTRL_WDT_EN = 0;
	localparam int CTRL_SLEEP  = 1;
	localparam int CTRL_CLRWDT = 2;
	// interrupt control register fields
	localparam int INTC_GATE    = 7;
	localparam int INTC_CMP_EN  = 6;
	localparam int INTC_EDGE_EN = 4;
	localparam int INTC_CHG_EN  = 3;
	localparam int INTC_CMP_F   = 2;
	localparam int INTC_EDGE_F  = 1;
	localparam int INTC_CHG_F   = 0;
	// status and port register fields
	localparam int STAT_ASLEEP = 5;
	localparam int STAT_TO     = 4;
	localparam int STAT_PD     = 3;
	localparam int PORT_OE_LSB = 8;
	// reset values and interrupt vector address
	localparam logic [7:0]  INTC_RESET    = 8'h00;
	localparam logic [7:0]  SCRATCH_RESET = 8'h00;
	localparam logic [7:0]  PORT_OE_RESET = 8'h00;
	localparam logic [12:0] VECTOR_ADDR   = 13'h0004;
	// timing
	localparam int CLK_PERIOD_NS    = 50;
	localparam int CLR_MIN_PULSE_NS = 2000;
	localparam int CLR_FILT_CYC     = (CLR_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OSC_START_CYC    = 1024;
	localparam int WDT_PERIOD_CYC   = 65536;
	// reset and wake causes
	typedef enum logic [2:0] {
		CAUSE_POR       = 3'h0,
		CAUSE_CLR_RUN   = 3'h1,
		CAUSE_CLR_SLEEP = 3'h2,
		CAUSE_WDT_RUN   = 3'h3,
		CAUSE_WDT_WAKE  = 3'h4,
		CAUSE_SUPPLY    = 3'h5
	} rswc_cause_t;
	// sleep and wake sequencer states
	typedef enum logic [2:0] {
		ST_RUN   = 3'h0,
		ST_SLEEP = 3'h1,
		ST_OSC   = 3'h2,
		ST_EXEC  = 3'h3,
		ST_DUMMY = 3'h4,
		ST_VECT  = 3'h5
	} rswc_state_t;
endpackage

// ===== include/rswc_clr_if.sv
/*
 * Carrier between the controller and its clear-pin filter.
 * Assumes both ends sit on the same core clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface rswc_clr_if;
	logic ce;
	logic raw_b;
	logic active;
	modport filt (input ce, input raw_b, output active);
	modport core (output ce, output raw_b, input active);
endinterface
`default_nettype wire

// ===== core/rswc_clr_filter.sv
/*
 * Glitch filter for the active-low external clear pin.
 * Assumes the pin is already synchronous to the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module rswc_clr_filter #(
	parameter int FILT_CYC = rswc_pkg::CLR_FILT_CYC
) (
	// clock and reset
	input wire logic   core_clk_in,
	input wire logic   rst_b_in,
	// pin in, filtered level out
	rswc_clr_if.filt   clr
);
	import rswc_pkg::*;

	localparam int CW = $clog2(FILT_CYC + 1);

	logic [CW-1:0] low_cnt_q;
	logic          active_q;

	// a zero-length filter would pass every glitch
	if (FILT_CYC < 1) begin : g_chk
		$error("rswc_clr_filter: FILT_CYC must be at least 1");
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			low_cnt_q <= '0;
			active_q  <= 1'b0;
		end else if (clr.ce) begin
			if (clr.raw_b) begin
				low_cnt_q <= '0;
				active_q  <= 1'b0;
			end else if (low_cnt_q == CW'(FILT_CYC - 1)) begin
				active_q <= 1'b1;
			end else begin
				low_cnt_q <= low_cnt_q + 1'b1;
			end
		end
	end

	assign clr.active = active_q;

	AST_CLR_FILTER: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
		$rose(active_q) |-> (low_cnt_q == CW'(FILT_CYC - 1)) && $past(!clr.raw_b))
		else $error("clear accepted before the filter time");
endmodule
`default_nettype wire

// ===== core/rswc_top.sv
/*
 * Reset classification, sleep entry and wake sequencing for a small
 * 8-bit core, with an AHB-Lite register slave.
 * Assumes one 20 MHz clock, power-up reset on rst_b_in, and pins that
 * are synchronous to the clock.
 *
 */
// The AHB-Lite register port and the register addresses were decided locally.
// Overview of operation
// - classify six reset and wake causes
// - keep register untouched by any reset
// - most registers reset except watchdog wake
// - filter glitches on the clear pin
// - sleep clears watchdog and PD flag, sets TO flag, stops oscillator
// - port pins hold drive state asleep
// - watchdog reset stays internal, pin untouched
// - wake on clear, watchdog or interrupt
// - clear wake resets, others resume
// - sleep flag set at power-up, cleared
// - watchdog wake clears expiry flag
// - prefetch next instruction during sleep entry
// - enabled source wakes regardless of gate
// - run prefetched, vector only if gate set
// - pending enabled flag wakes at once
// - clear watchdog on every wake
// - flags set regardless of enables
// - global gate is interrupt control bit seven
`timescale 1ns/1ps
`default_nettype none
module rswc_top #(
	parameter int WDT_CYC  = rswc_pkg::WDT_PERIOD_CYC,
	parameter int OST_CYC  = rswc_pkg::OSC_START_CYC,
	parameter int FILT_CYC = rswc_pkg::CLR_FILT_CYC
) (
	// clock, reset, enable
	input wire logic             core_clk_in,
	input wire logic             rst_b_in,
	input wire logic             ce_in,
	// AHB-Lite slave
	input wire logic             hsel_in,
	input wire logic [31:0]      haddr_in,
	input wire logic [1:0]       htrans_in,
	input wire logic             hwrite_in,
	input wire logic [2:0]       hsize_in,
	input wire logic             hready_in,
	input wire logic [31:0]      hwdata_in,
	output logic [31:0]          hrdata_out,
	output logic                 hreadyout_out,
	output logic                 hresp_out,
	// reset and wake sources
	input wire logic             external_clear_pin_b_in,
	input wire logic             supply_drop_reset_in,
	input wire logic             edge_interrupt_pin_in,
	input wire logic [3:0]       port_change_pins_in,
	input wire logic             cmp_event_in,
	// core control
	output logic                 core_rst_out,
	output logic                 osc_run_out,
	output logic                 asleep_out,
	output logic                 prefetch_out,
	output logic                 exec_next_out,
	output logic                 dummy_cycle_out,
	output logic                 vector_jump_out,
	output logic [12:0]          vector_addr_out,
	output rswc_pkg::rswc_cause_t reset_cause_out,
	// port drive
	output logic [7:0]           port_data_out,
	output logic [7:0]           port_oe_out
);
	import rswc_pkg::*;

	localparam int WW = $clog2(WDT_CYC);
	localparam int OW = $clog2(OST_CYC + 1);

	if (WDT_CYC < 2 || OST_CYC < 1) begin : g_chk
		$error("rswc_top: WDT_CYC must be >= 2 and OST_CYC >= 1");
	end

	rswc_clr_if  clr ();
	rswc_state_t state_q;
	rswc_cause_t cause_q;
	logic [WW-1:0] wdt_cnt_q;
	logic [OW-1:0] ost_cnt_q;
	logic [7:0]  intc_q, keep_q, scratch_q, port_q, oe_q;
	logic [31:0] rdv;
	logic [7:0]  raddr_q, waddr_q;
	logic        wr_q, rd_pend_q, acc;
	logic        wdt_en_q, to_q, pd_q, clr_q, edge_q, core_rst_q, prefetch_q;
	logic        wake_int_q;
	logic [3:0]  chg_q;
	logic        wr_ctrl, sleep_go, clrwdt, wdt_exp, wdt_wake, wdt_run_rst;
	logic        clr_new, soft_rst, pend, wake;

	// pin filter; the clear pin is only ever an input here
	assign clr.ce    = ce_in;
	assign clr.raw_b = external_clear_pin_b_in;
	rswc_clr_filter #(.FILT_CYC(FILT_CYC)) u_filt (
		.core_clk_in (core_clk_in),
		.rst_b_in    (rst_b_in),
		.clr         (clr)
	);

	// event decode
	assign wr_ctrl     = wr_q && (waddr_q == ADDR_CTRL);
	assign sleep_go    = wr_ctrl && hwdata_in[CTRL_SLEEP] && (state_q == ST_RUN) && !soft_rst;
	assign clrwdt      = wr_ctrl && hwdata_in[CTRL_CLRWDT];
	assign wdt_exp     = wdt_en_q && (wdt_cnt_q == WW'(WDT_CYC - 1));
	assign clr_new     = clr.active && !clr_q;
	assign wdt_wake    = wdt_exp && (state_q == ST_SLEEP) && !clr.active;
	assign wdt_run_rst = wdt_exp && (state_q != ST_SLEEP);
	assign soft_rst    = clr.active || supply_drop_reset_in || wdt_run_rst;
	assign pend = (intc_q[INTC_CMP_EN] && intc_q[INTC_CMP_F]) ||
		(intc_q[INTC_EDGE_EN] && intc_q[INTC_EDGE_F]) ||
		(intc_q[INTC_CHG_EN] && intc_q[INTC_CHG_F]);
	assign wake = (state_q == ST_SLEEP) && !clr.active && (wdt_wake || pend);

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cause_q    <= CAUSE_POR;
			clr_q      <= 1'b0;
			core_rst_q <= 1'b0;
		end else if (ce_in) begin
			clr_q      <= clr.active;
			core_rst_q <= soft_rst;
			if (clr_new) begin
				cause_q <= (state_q == ST_SLEEP) ? CAUSE_CLR_SLEEP : CAUSE_CLR_RUN;
			end else if (supply_drop_reset_in) begin
				cause_q <= CAUSE_SUPPLY;
			end else if (wdt_run_rst) begin
				cause_q <= CAUSE_WDT_RUN;
			end else if (wdt_wake) begin
				cause_q <= CAUSE_WDT_WAKE;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q    <= ST_RUN;
			ost_cnt_q  <= '0;
			wake_int_q <= 1'b0;
		end else if (ce_in) begin
			if (soft_rst) begin
				state_q <= ST_RUN;
			end else begin
				unique case (state_q)
					ST_RUN: begin
						if (sleep_go) begin
							state_q <= ST_SLEEP;
						end
					end
					ST_SLEEP: begin
						if (wake) begin
							state_q    <= ST_OSC;
							ost_cnt_q  <= OW'(OST_CYC - 1);
							wake_int_q <= !wdt_wake;
						end
					end
					ST_OSC: begin
						if (ost_cnt_q == '0) begin
							state_q <= ST_EXEC;
						end else begin
							ost_cnt_q <= ost_cnt_q - 1'b1;
						end
					end
					ST_EXEC: begin
						state_q <= (wake_int_q && intc_q[INTC_GATE]) ? ST_DUMMY : ST_RUN;
					end
					ST_DUMMY: begin
						state_q <= ST_VECT;
					end
					ST_VECT: begin
						state_q <= ST_RUN;
					end
					default: begin
						state_q <= ST_RUN;
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			prefetch_q      <= 1'b0;
			vector_addr_out <= 13'h0000;
		end else if (ce_in) begin
			prefetch_q <= sleep_go;
			if (state_q == ST_DUMMY) begin
				vector_addr_out <= VECTOR_ADDR;
			end
		end
	end

	// watchdog count; cleared on sleep, clear and every wake
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wdt_cnt_q <= '0;
		end else if (ce_in) begin
			if (sleep_go || clrwdt || wake || soft_rst || wdt_exp) begin
				wdt_cnt_q <= '0;
			end else if (wdt_en_q) begin
				wdt_cnt_q <= wdt_cnt_q + 1'b1;
			end
		end
	end

	// status flags; expiry flag cleared on watchdog events
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			to_q <= 1'b1;
			pd_q <= 1'b1;
		end else if (ce_in) begin
			if (supply_drop_reset_in) begin
				to_q <= 1'b1;
				pd_q <= 1'b1;
			end else if (clr_new && state_q == ST_SLEEP) begin
				to_q <= 1'b1;
				pd_q <= 1'b0;
			end else if (wdt_run_rst || wdt_wake) begin
				to_q <= 1'b0;
			end else if (sleep_go) begin
				to_q <= 1'b1;
				pd_q <= 1'b0;
			end else if (clrwdt) begin
				to_q <= 1'b1;
				pd_q <= 1'b1;
			end
		end
	end

	// flags set independent of enables; set beats a clearing write
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			intc_q <= INTC_RESET;
			edge_q <= 1'b0;
			chg_q  <= 4'h0;
		end else if (ce_in) begin
			edge_q <= edge_interrupt_pin_in;
			chg_q  <= port_change_pins_in;
			if (soft_rst) begin
				// reset state; change flag keeps its value
				intc_q <= {INTC_RESET[7:1], intc_q[INTC_CHG_F]};
			end else begin
				intc_q <= (wr_q && waddr_q == ADDR_INTC) ? hwdata_in[7:0] : intc_q;
				if (edge_interrupt_pin_in && !edge_q) begin
					intc_q[INTC_EDGE_F] <= 1'b1;
				end
				if (port_change_pins_in != chg_q) begin
					intc_q[INTC_CHG_F] <= 1'b1;
				end
				if (cmp_event_in) begin
					intc_q[INTC_CMP_F] <= 1'b1;
				end
			end
		end
	end

	// software registers; watchdog enable is kept through soft resets
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wdt_en_q  <= 1'b0;
			scratch_q <= SCRATCH_RESET;
			oe_q      <= PORT_OE_RESET;
		end else if (ce_in) begin
			if (wr_ctrl) begin
				wdt_en_q <= hwdata_in[CTRL_WDT_EN];
			end
			if (soft_rst) begin
				scratch_q <= SCRATCH_RESET;
				oe_q      <= PORT_OE_RESET;
			end else begin
				if (wr_q && waddr_q == ADDR_SCRATCH) begin
					scratch_q <= hwdata_in[7:0];
				end
				if (wr_q && waddr_q == ADDR_PORT && state_q != ST_SLEEP) begin
					oe_q <= hwdata_in[PORT_OE_LSB+7:PORT_OE_LSB];
				end
			end
		end
	end

	// no reset at all: unknown at power-up, kept through every cause
	always_ff @(posedge core_clk_in) begin
		if (ce_in && wr_q && waddr_q == ADDR_KEEP) begin
			keep_q <= hwdata_in[7:0];
		end
		if (ce_in && wr_q && waddr_q == ADDR_PORT && state_q != ST_SLEEP) begin
			port_q <= hwdata_in[7:0];
		end
	end

	// read mux; reserved bits and unmapped words read zero
	always_comb begin
		rdv = 32'h0000_0000;
		unique case (raddr_q)
			ADDR_CTRL:    rdv[CTRL_WDT_EN] = wdt_en_q;
			ADDR_INTC:    rdv[7:0] = intc_q;
			ADDR_STAT:    rdv[7:0] = {2'h0, state_q == ST_SLEEP, to_q, pd_q, cause_q};
			ADDR_KEEP:    rdv[7:0] = keep_q;
			ADDR_SCRATCH: rdv[7:0] = scratch_q;
			ADDR_PORT:    rdv[15:0] = {oe_q, port_q};
			default:      rdv = 32'h0000_0000;
		endcase
	end

	// bus slave; reads take one wait state so a write just before is seen
	assign acc = hsel_in && htrans_in[1] && hready_in;
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_q       <= 1'b0;
			rd_pend_q  <= 1'b0;
			waddr_q    <= 8'h00;
			raddr_q    <= 8'h00;
			hrdata_out <= 32'h0000_0000;
		end else if (ce_in) begin
			wr_q      <= acc && hwrite_in;
			rd_pend_q <= acc && !hwrite_in;
			if (acc) begin
				waddr_q <= {haddr_in[7:2], 2'h0};
				raddr_q <= {haddr_in[7:2], 2'h0};
			end
			if (rd_pend_q) begin
				hrdata_out <= rdv;
			end
		end
	end

	// outputs
	assign hreadyout_out   = !rd_pend_q;
	assign hresp_out       = 1'b0;
	assign core_rst_out    = core_rst_q;
	assign osc_run_out     = (state_q != ST_SLEEP);
	assign asleep_out      = (state_q == ST_SLEEP);
	assign prefetch_out    = prefetch_q;
	assign exec_next_out   = (state_q == ST_EXEC);
	assign dummy_cycle_out = (state_q == ST_DUMMY);
	assign vector_jump_out = (state_q == ST_VECT);
	assign reset_cause_out = cause_q;
	assign port_data_out   = port_q;
	assign port_oe_out     = oe_q;

	default clocking cb @(posedge core_clk_in iff ce_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_gate_wake;
		(state_q == ST_EXEC) && wake_int_q && intc_q[INTC_GATE] && !soft_rst;
	endsequence
	sequence s_vector_path;
		dummy_cycle_out ##1 (vector_jump_out && vector_addr_out == VECTOR_ADDR);
	endsequence

	AST_SLEEP_ENTRY: assert property (sleep_go |=> !pd_q && to_q && !osc_run_out && wdt_cnt_q == '0)
		else $error("sleep entry effects missing");
	AST_PREFETCH: assert property (sleep_go |=> prefetch_out ##1 !prefetch_out)
		else $error("prefetch pulse wrong");
	AST_PORT_HOLD: assert property (asleep_out && !soft_rst |=> $stable(port_oe_out) && $stable(port_data_out))
		else $error("port drive changed asleep");
	AST_WDT_WAKE: assert property (wdt_wake |=> !to_q && !core_rst_out && state_q == ST_OSC
		&& reset_cause_out == CAUSE_WDT_WAKE)
		else $error("watchdog wake handled wrong");
	AST_WAKE_CLR_WDT: assert property (wake |=> wdt_cnt_q == '0)
		else $error("watchdog not cleared on wake");
	AST_INT_WAKE: assert property ((state_q == ST_SLEEP) && pend && !soft_rst |=> state_q == ST_OSC)
		else $error("enabled pending flag did not wake");
	AST_OSC_WAIT: assert property ((state_q == ST_OSC) && ost_cnt_q == '0 && !soft_rst
		|-> !exec_next_out ##1 exec_next_out)
		else $error("oscillator wait exit wrong");
	AST_VECTOR: assert property (s_gate_wake |=> s_vector_path)
		else $error("vector branch sequence wrong");
	AST_INLINE: assert property (exec_next_out && !(wake_int_q && intc_q[INTC_GATE]) && !soft_rst
		|=> state_q == ST_RUN && !vector_jump_out)
		else $error("branched without the gate");
	AST_WDT_RESET: assert property (wdt_run_rst && !clr.active && !supply_drop_reset_in
		|=> core_rst_out && reset_cause_out == CAUSE_WDT_RUN && !to_q)
		else $error("watchdog reset wrong");
	AST_CLR_SLEEP: assert property (clr_new && asleep_out |=> core_rst_out
		&& reset_cause_out == CAUSE_CLR_SLEEP && state_q == ST_RUN)
		else $error("clear wake did not reset");
	AST_KEEP: assert property (core_rst_out && !wr_q |=> $stable(keep_q))
		else $error("keep register disturbed by reset");
	AST_SCRATCH: assert property (soft_rst |=> scratch_q == SCRATCH_RESET)
		else $error("scratch not reset");
endmodule
`default_nettype wire

// ===== verification/rswc_src_model.sv
/*
 * Behavioural far side of the controller: the clear pin and the
 * interrupt sources, driven on command from the testbench.
 * Assumes it shares the core clock and drives just after rising edges.
 */
`timescale 1ns/1ps
`default_nettype none
module rswc_src_model (
	// clock
	input wire logic  core_clk_in,
	// pin and source drive
	output logic      clr_pin_b_out,
	output logic      edge_pin_out,
	output logic [3:0] chg_pins_out,
	output logic      cmp_event_out
);
	// idle levels: pin released high, no events
	initial begin
		clr_pin_b_out = 1'b1;
		edge_pin_out = 1'b0;
		chg_pins_out = 4'h0;
		cmp_event_out = 1'b0;
	end
	task automatic pulse_clr(input int n);
		@(posedge core_clk_in);
		clr_pin_b_out <= 1'b0;
		repeat (n) @(posedge core_clk_in);
		clr_pin_b_out <= 1'b1;
	endtask
	task automatic pulse_chg();
		@(posedge core_clk_in);
		chg_pins_out <= chg_pins_out ^ 4'h1;
	endtask
	task automatic pulse_src(input logic is_cmp);
		@(posedge core_clk_in);
		if (is_cmp) cmp_event_out <= 1'b1;
		else edge_pin_out <= 1'b1;
		@(posedge core_clk_in);
		cmp_event_out <= 1'b0;
		edge_pin_out <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== verification/rswc_top_tb.sv
/*
 * Self-checking bench for the reset, sleep and wake controller.
 * Assumes the design files and package are compiled first; short
 * watchdog, oscillator and filter counts keep the run brief.
 */
`timescale 1ns/1ps
`default_nettype none
module rswc_top_tb;
	import rswc_pkg::*;
	localparam int WDT = 64;
	localparam int OST = 4;
	localparam int FLT = 3;
	logic clk, rst_b, hwrite, hready, supply, clr_b, edge_p, cmp, hresp;
	logic [1:0] htrans;
	logic [3:0] chg;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic core_rst, osc_run, asleep, pref, exec_nx, dummy, vect, dummy_d;
	logic [12:0] vaddr;
	logic [7:0] pdata, poe;
	rswc_cause_t cause;
	int n_errors, comparisons, n_exec, n_vec, n_pref, n_rst, bad_seq, e0, v0;

	rswc_top #(.WDT_CYC(WDT), .OST_CYC(OST), .FILT_CYC(FLT)) u_rswc_top (
		.core_clk_in(clk), .rst_b_in(rst_b), .ce_in(1'b1),
		.hsel_in(1'b1), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hready_in(hready), .hwdata_in(hwdata), .hrdata_out(hrdata),
		.hreadyout_out(hready), .hresp_out(hresp),
		.external_clear_pin_b_in(clr_b), .supply_drop_reset_in(supply),
		.edge_interrupt_pin_in(edge_p), .port_change_pins_in(chg), .cmp_event_in(cmp),
		.core_rst_out(core_rst), .osc_run_out(osc_run), .asleep_out(asleep),
		.prefetch_out(pref), .exec_next_out(exec_nx), .dummy_cycle_out(dummy),
		.vector_jump_out(vect), .vector_addr_out(vaddr), .reset_cause_out(cause),
		.port_data_out(pdata), .port_oe_out(poe));
	rswc_src_model u_rswc_src_model (.core_clk_in(clk), .clr_pin_b_out(clr_b),
		.edge_pin_out(edge_p), .chg_pins_out(chg), .cmp_event_out(cmp));

	// clock at 50 ns period
	always #25 clk = ~clk;
	// count pulses mid-cycle, where outputs are settled
	always @(negedge clk) begin
		if (exec_nx === 1'b1) n_exec++;
		if (pref === 1'b1) n_pref++;
		if (vect === 1'b1) n_vec++;
		if (vect === 1'b1 && (dummy_d !== 1'b1 || vaddr !== VECTOR_ADDR)) bad_seq++;
		if (core_rst === 1'b1) n_rst++;
		dummy_d = dummy;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// bounded wait for hready at a rising edge
	task automatic wait_rdy();
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hready !== 1'b1 && k < 50);
		if (k >= 50) chk(32'h0, 32'h1);
	endtask
	// one single word transfer; address phase held until hready
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	function automatic logic [31:0] st(input logic [2:0] c, input logic to, input logic pd, input logic sl);
		st = 32'h0;
		st[2:0] = c;
		st[STAT_TO] = to;
		st[STAT_PD] = pd;
		st[STAT_ASLEEP] = sl;
	endfunction
	// wait for the resume pulse, then check vector branch count
	task automatic wake(input int lim, input int vecs);
		int i;
		e0 = n_exec;
		v0 = n_vec;
		for (i = 0; i < lim && n_exec == e0; i++) @(posedge clk);
		repeat (4) @(posedge clk);
		chk(32'(n_exec - e0), 32'h1);
		chk(32'(n_vec - v0), 32'(vecs));
		chk(32'(bad_seq), 32'h0);
	endtask
	// wait for an internal reset and its end
	task automatic wait_rst(input int lim);
		int i;
		e0 = n_rst;
		for (i = 0; i < lim && n_rst == e0; i++) @(posedge clk);
		for (i = 0; i < 20 && core_rst !== 1'b0; i++) @(posedge clk);
		chk(32'(n_rst > e0), 32'h1);
	endtask

	// hang guard, well past the expected run
	initial begin
		#500000;
		n_errors++;
		$display("ERROR at %0t: timeout got %h expected %h", $time, 0, 1);
		tally_and_finish();
	end
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		supply = 1'b0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		rchk(ADDR_STAT, st(3'h0, 1'b1, 1'b1, 1'b0));
		rchk(ADDR_INTC, {24'h0, INTC_RESET});
		rchk(8'h20, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		bus(1'b1, ADDR_KEEP, 32'h5A);
		bus(1'b1, ADDR_SCRATCH, 32'h33);
		bus(1'b1, ADDR_PORT, 32'h0FA5);
		rchk(ADDR_PORT, 32'h0FA5);
		// glitch shorter than the filter
		u_rswc_src_model.pulse_clr(FLT - 1);
		repeat (8) @(posedge clk);
		chk(32'(n_rst), 32'h0);
		rchk(ADDR_SCRATCH, 32'h33);
		// interrupt wake with gate set
		bus(1'b1, ADDR_INTC, 32'h90);
		bus(1'b1, ADDR_CTRL, 32'h2);
		@(negedge clk);
		chk({29'h0, asleep, osc_run, 1'b0}, 32'h4);
		rchk(ADDR_STAT, st(3'h0, 1'b1, 1'b0, 1'b1));
		chk(32'(n_pref), 32'h1);
		bus(1'b1, ADDR_PORT, 32'h00FF);
		chk({24'h0, poe}, 32'h0F);
		chk({24'h0, pdata}, 32'hA5);
		u_rswc_src_model.pulse_src(1'b0);
		wake(OST + 20, 1);
		rchk(ADDR_SCRATCH, 32'h33);
		// pending enabled flag, gate clear
		bus(1'b1, ADDR_INTC, 32'h12);
		bus(1'b1, ADDR_CTRL, 32'h2);
		wake(OST + 20, 0);
		// disabled source must not wake; watchdog wake instead
		bus(1'b1, ADDR_INTC, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h3);
		u_rswc_src_model.pulse_src(1'b1);
		u_rswc_src_model.pulse_chg();
		repeat (8) @(posedge clk);
		chk({31'h0, asleep}, 32'h1);
		rchk(ADDR_INTC, 32'h05);
		wake(WDT + OST + 40, 0);
		repeat (WDT - 24) @(posedge clk);
		chk(32'(n_rst), 32'h0);
		rchk(ADDR_STAT, st(3'h4, 1'b0, 1'b0, 1'b0));
		rchk(ADDR_SCRATCH, 32'h33);
		// watchdog expiry while running
		wait_rst(WDT + 20);
		bus(1'b1, ADDR_CTRL, 32'h0);
		rchk(ADDR_STAT, st(3'h3, 1'b0, 1'b0, 1'b0));
		rchk(ADDR_SCRATCH, {24'h0, SCRATCH_RESET});
		rchk(ADDR_KEEP, 32'h5A);
		chk({poe, pdata}, {PORT_OE_RESET, 8'hA5});
		// clear pin while asleep
		bus(1'b1, ADDR_SCRATCH, 32'h33);
		bus(1'b1, ADDR_CTRL, 32'h2);
		u_rswc_src_model.pulse_clr(FLT + 3);
		wait_rst(20);
		rchk(ADDR_STAT, st(3'h2, 1'b1, 1'b0, 1'b0));
		rchk(ADDR_SCRATCH, {24'h0, SCRATCH_RESET});
		rchk(ADDR_KEEP, 32'h5A);
		// clear pin while running, then supply drop
		u_rswc_src_model.pulse_clr(FLT + 3);
		wait_rst(20);
		bus(1'b0, ADDR_STAT, 32'h0);
		chk(rd & 32'h7, 32'h1);
		@(posedge clk);
		supply <= 1'b1;
		repeat (2) @(posedge clk);
		supply <= 1'b0;
		wait_rst(20);
		rchk(ADDR_STAT, st(3'h5, 1'b1, 1'b1, 1'b0));
		tally_and_finish();
	end
endmodule
`default_nettype wire
